// file: rtl/tc8_pkg.sv
// constants, carriers and state layout of the 8-bit timer/counter

package tc8_pkg;

    // ----------------------------------------------------------------
    // register word offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFF_CTRL_A = 8'h00;
    localparam logic [ADR_W-1:0] OFF_CTRL_B = 8'h04;
    localparam logic [ADR_W-1:0] OFF_CTRL_C = 8'h08;
    localparam logic [ADR_W-1:0] OFF_COUNT = 8'h0c;
    localparam logic [ADR_W-1:0] OFF_CMP_A = 8'h10;
    localparam logic [ADR_W-1:0] OFF_CMP_B = 8'h14;
    localparam logic [ADR_W-1:0] OFF_FLAG = 8'h18;
    localparam logic [ADR_W-1:0] OFF_MASK = 8'h1c;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CA_COM_A_LSB = 6;
    localparam int CA_COM_B_LSB = 4;
    localparam int CA_WAVE_LSB = 0;
    localparam int CB_WAVE2_BIT = 3;
    localparam int CB_CS_LSB = 0;
    localparam int CC_FORCE_A_BIT = 7;
    localparam int CC_FORCE_B_BIT = 6;
    localparam int FL_OVF = 0;
    localparam int FL_CMP_A = 1;
    localparam int FL_CMP_B = 2;

    // ----------------------------------------------------------------
    // count limits and encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRE_W = 10;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [2:0] RST_MASK = 3'h0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADR_W-1:0] adr;
        logic [31:0] dat;
    } tc8_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } tc8_wb_rsp_t;

    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] wave;
        logic [2:0] cs;
        logic [2:0] mask;
        logic [2:0] flags;
        logic [7:0] cnt;
        logic down;
        logic blk;
        logic [7:0] buf_a;
        logic [7:0] buf_b;
        logic [7:0] act_a;
        logic [7:0] act_b;
        logic oc_a;
        logic oc_b;
        logic [PRE_W-1:0] pre;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic ack;
        logic [31:0] dat;
    } tc8_state_t;

endpackage

// file: rtl/tc8_timer.sv
// 8-bit timer/counter with two compare units behind a wishbone slave
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps

module tc8_timer (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register bus
    input wire tc8_pkg::tc8_wb_req_t wb_i,
    output tc8_pkg::tc8_wb_rsp_t wb_o,
    // external count pin, asynchronous
    input wire logic external_count_pin_i,
    // interrupt requests and their executed strobes
    output logic [2:0] irq_req_o,
    input wire logic [2:0] irq_done_i,
    // compare outputs and port override enables
    output logic compare_output_a_o,
    output logic compare_output_b_o,
    output logic override_a_o,
    output logic override_b_o
);
    import tc8_pkg::*;

    // ----------------------------------------------------------------
    // compare output update
    // ----------------------------------------------------------------
    // one shared rule set for both units; mode zero never acts
    function automatic logic oc_upd(input logic oc, input logic [1:0] com,
                                    input logic m, input logic bot,
                                    input logic pwm, input logic up);
        logic r;
        r = oc;
        if (!pwm) begin
            if (m) begin
                case (com)
                    2'h1: r = ~oc;
                    2'h2: r = 1'b0;
                    2'h3: r = 1'b1;
                    default: r = oc;
                endcase
            end
        end else if (com[1]) begin
            if (bot) begin
                r = ~com[0];
            end else if (m) begin
                r = com[0] ^ ~up;
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tc8_state_t st_reg;
    tc8_state_t st_next;

    logic acc;
    logic wr;
    logic hit_ca, hit_cb, hit_cc, hit_cnt, hit_ma, hit_mb, hit_fl, hit_mk;
    logic tick;
    logic is_pwm, is_fast, is_phase, is_ctc;
    logic [7:0] top;
    logic [7:0] wdat;
    logic m_a, m_b, ev_a, ev_b, ovf, bot;
    logic [2:0] clr;
    logic [31:0] rdat;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        wdat = wb_i.dat[7:0];
        acc = wb_i.cyc & wb_i.stb;
        // write commits on the edge where ack is seen high by the master
        wr = acc & wb_i.we & st_reg.ack & wb_i.sel[0];
        hit_ca = 1'b0;
        hit_cb = 1'b0;
        hit_cc = 1'b0;
        hit_cnt = 1'b0;
        hit_ma = 1'b0;
        hit_mb = 1'b0;
        hit_fl = 1'b0;
        hit_mk = 1'b0;
        rdat = 32'h0000_0000;
        // address decode; unmapped words ack and read zero
        if (wb_i.adr == OFF_CTRL_A) begin
            hit_ca = wr;
            rdat[7:0] = {st_reg.com_a, st_reg.com_b, 2'h0,
                         st_reg.wave[1:0]};
        end else if (wb_i.adr == OFF_CTRL_B) begin
            hit_cb = wr;
            rdat[7:0] = {4'h0, st_reg.wave[2], st_reg.cs};
        end else if (wb_i.adr == OFF_CTRL_C) begin
            hit_cc = wr; // strobes read back as zero
        end else if (wb_i.adr == OFF_COUNT) begin
            hit_cnt = wr;
            rdat[7:0] = st_reg.cnt;
        end else if (wb_i.adr == OFF_CMP_A) begin
            hit_ma = wr;
            rdat[7:0] = st_reg.buf_a;
        end else if (wb_i.adr == OFF_CMP_B) begin
            hit_mb = wr;
            rdat[7:0] = st_reg.buf_b;
        end else if (wb_i.adr == OFF_FLAG) begin
            hit_fl = wr;
            rdat[2:0] = st_reg.flags;
        end else if (wb_i.adr == OFF_MASK) begin
            hit_mk = wr;
            rdat[2:0] = st_reg.mask;
        end
        st_next.ack = acc & ~st_reg.ack;
        if (acc & ~st_reg.ack) begin
            st_next.dat = rdat;
        end

        // mode decode from the three wave bits
        is_pwm = st_reg.wave[0];
        is_fast = st_reg.wave[0] & st_reg.wave[1];
        is_phase = st_reg.wave[0] & ~st_reg.wave[1];
        is_ctc = (st_reg.wave == WM_CTC);
        top = (is_ctc | st_reg.wave[2]) ? st_reg.act_a : CNT_MAX;

        // pin synchroniser; only the second and third stages are compared
        st_next.ext_s1 = external_count_pin_i;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;

        // prescaler runs only while a source is chosen
        st_next.pre = (st_reg.cs == CS_STOP) ? '0 : st_reg.pre + 1'b1;
        case (st_reg.cs)
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = &st_reg.pre[2:0];
            CS_DIV64: tick = &st_reg.pre[5:0];
            CS_DIV256: tick = &st_reg.pre[7:0];
            CS_DIV1024: tick = &st_reg.pre[9:0];
            CS_EXT_FALL: tick = st_reg.ext_s3 & ~st_reg.ext_s2;
            CS_EXT_RISE: tick = st_reg.ext_s2 & ~st_reg.ext_s3;
            default: tick = 1'b0;
        endcase

        // comparators, always live
        m_a = (st_reg.cnt == st_reg.act_a);
        m_b = (st_reg.cnt == st_reg.act_b);
        // a match counts only on a tick that no count write blocks
        ev_a = tick & m_a & ~st_reg.blk;
        ev_b = tick & m_b & ~st_reg.blk;
        ovf = 1'b0;
        bot = 1'b0;

        // counter sequence per mode
        if (tick) begin
            if (is_fast) begin
                bot = (st_reg.cnt == top);
                st_next.cnt = bot ? CNT_BOTTOM : st_reg.cnt + 8'h01;
                ovf = bot;
                st_next.down = 1'b0;
            end else if (is_phase) begin
                if (!st_reg.down) begin
                    if (st_reg.cnt == top) begin
                        st_next.down = 1'b1;
                        st_next.cnt = st_reg.cnt - 8'h01;
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                    end
                end else if (st_reg.cnt == CNT_BOTTOM) begin
                    st_next.down = 1'b0;
                    st_next.cnt = st_reg.cnt + 8'h01;
                    ovf = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h01;
                end
            end else begin
                // normal and clear-on-match count up; normal wraps at max, clear-on-match clears on a compare a match
                st_next.cnt = (is_ctc && m_a) ? CNT_BOTTOM
                                              : st_reg.cnt + 8'h01;
                ovf = (st_reg.cnt == CNT_MAX);
                st_next.down = 1'b0;
            end
            // buffered compare values load at top of the sequence
            if (is_pwm && st_reg.cnt == top) begin
                st_next.act_a = st_reg.buf_a;
                st_next.act_b = st_reg.buf_b;
            end
            st_next.blk = 1'b0;
        end
        if (!is_phase) begin
            st_next.down = 1'b0;
        end

        // compare outputs; mode bits read straight from the register
        st_next.oc_a = oc_upd(st_reg.oc_a, st_reg.com_a, ev_a, bot,
                              is_pwm, ~st_reg.down);
        st_next.oc_b = oc_upd(st_reg.oc_b, st_reg.com_b, ev_b, bot,
                              is_pwm, ~st_reg.down);
        // force acts like a match on the output alone
        if (hit_cc && !is_pwm && wdat[CC_FORCE_A_BIT]) begin
            st_next.oc_a = oc_upd(st_reg.oc_a, st_reg.com_a, 1'b1, 1'b0,
                                  1'b0, 1'b1);
        end
        if (hit_cc && !is_pwm && wdat[CC_FORCE_B_BIT]) begin
            st_next.oc_b = oc_upd(st_reg.oc_b, st_reg.com_b, 1'b1, 1'b0,
                                  1'b0, 1'b1);
        end

        // flags: set beats clear so no event is lost on a clear
        clr = irq_done_i;
        if (hit_fl) begin
            clr = clr | wdat[2:0];
        end
        st_next.flags = (st_reg.flags & ~clr)
                        | {ev_b, ev_a, ovf};

        // control register writes
        if (hit_ca) begin
            st_next.com_a = wdat[CA_COM_A_LSB +: 2];
            st_next.com_b = wdat[CA_COM_B_LSB +: 2];
            st_next.wave[1:0] = wdat[CA_WAVE_LSB +: 2];
        end
        if (hit_cb) begin
            st_next.wave[2] = wdat[CB_WAVE2_BIT];
            st_next.cs = wdat[CB_CS_LSB +: 3];
        end
        if (hit_mk) begin
            st_next.mask = wdat[2:0];
        end
        if (hit_ma) begin
            st_next.buf_a = wdat;
        end
        if (hit_mb) begin
            st_next.buf_b = wdat;
        end
        // without pwm the active value follows the written one directly
        if (!is_pwm) begin
            st_next.act_a = st_reg.buf_a;
            st_next.act_b = st_reg.buf_b;
        end
        // a software count write wins and arms the match block
        if (hit_cnt) begin
            st_next.cnt = wdat;
            st_next.blk = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register; oc states are not touched by mode writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.cnt <= RST_CNT;
            st_reg.buf_a <= RST_CMP;
            st_reg.buf_b <= RST_CMP;
            st_reg.act_a <= RST_CMP;
            st_reg.act_b <= RST_CMP;
            st_reg.flags <= RST_FLAGS;
            st_reg.mask <= RST_MASK;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_o.ack = st_reg.ack;
    assign wb_o.dat = st_reg.dat;
    assign irq_req_o = st_reg.flags & st_reg.mask;
    assign compare_output_a_o = st_reg.oc_a;
    assign compare_output_b_o = st_reg.oc_b;
    // pin direction stays with the port; only the value is taken over
    assign override_a_o = |st_reg.com_a;
    assign override_b_o = |st_reg.com_b;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_cnt_wr;
        ce_i && hit_cnt;
    endsequence
    sequence s_blocked_tick;
        ce_i && tick && st_reg.blk && !hit_cnt && !st_reg.flags[FL_CMP_A]
            && irq_done_i == 3'h0 && !hit_fl;
    endsequence

    AST_STOPPED: assert property (
        ce_i && st_reg.cs == CS_STOP && !hit_cnt |=> $stable(st_reg.cnt))
        else $error("counter moved with no clock source");
    AST_WRITE_WINS: assert property (
        s_cnt_wr |=> st_reg.cnt == $past(wdat) && st_reg.blk)
        else $error("count write lost to counting");
    AST_BLOCK: assert property (
        s_blocked_tick |=> !st_reg.flags[FL_CMP_A])
        else $error("match not blocked after count write");
    AST_CMP_FLAG: assert property (
        ce_i && tick && m_a && !st_reg.blk |=> st_reg.flags[FL_CMP_A]
            ##0 irq_req_o[FL_CMP_A] == st_reg.mask[FL_CMP_A])
        else $error("compare flag a not set on tick after match");
    AST_FLAG_CLR: assert property (
        ce_i && hit_fl && wdat[FL_OVF] && !ovf |=> !st_reg.flags[FL_OVF])
        else $error("overflow flag not cleared by writing one");
    AST_DONE_CLR: assert property (
        ce_i && irq_done_i[FL_CMP_B] && !ev_b |=> !st_reg.flags[FL_CMP_B])
        else $error("compare flag b not cleared on interrupt done");
    AST_DBUF: assert property (
        ce_i && is_pwm && hit_ma && !(tick && st_reg.cnt == top)
            |=> $stable(st_reg.act_a))
        else $error("active compare changed off top in pwm");
    AST_DIRECT: assert property (
        ce_i && !is_pwm && hit_ma ##1 ce_i && !is_pwm
            |=> st_reg.act_a == $past(wdat, 2))
        else $error("compare write not direct in non-pwm mode");
    AST_FORCE: assert property (
        ce_i && hit_cc && !is_pwm && wdat[CC_FORCE_A_BIT]
            && st_reg.com_a == 2'h1 && !tick && !hit_fl
            && irq_done_i == 3'h0
            |=> st_reg.oc_a != $past(st_reg.oc_a)
            && st_reg.flags[FL_CMP_A] == $past(st_reg.flags[FL_CMP_A]))
        else $error("force compare did not toggle or touched flag");
    AST_WRAP: assert property (
        ce_i && tick && st_reg.wave == 3'h0 && st_reg.cnt == CNT_MAX
            && !irq_done_i[FL_OVF]
            && !hit_cnt |=> st_reg.cnt == CNT_BOTTOM
            && st_reg.flags[FL_OVF])
        else $error("normal mode wrap did not set overflow");

endmodule // tc8_timer

// file: sim/testbench.sv
// self-checking bench for the 8-bit timer/counter with compare units
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
    mismatches++; $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end end

module testbench;
    import tc8_pkg::*;

    // ------------------------------------------------------------
    // stimulus signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    tc8_wb_req_t wb_i = '0;
    tc8_wb_rsp_t wb_o;
    logic external_count_pin_i = 1'b0;
    logic [2:0] irq_req_o;
    logic [2:0] irq_done_i = 3'h0;
    logic compare_output_a_o;
    logic compare_output_b_o;
    logic override_a_o;
    logic override_b_o;
    int mismatches = 0;
    int check_count = 0;
    logic [7:0] q;
    logic oc_before;

    // 40 mhz clock
    always #12.5 clk_i = ~clk_i;

    tc8_timer u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_o(wb_o),
        .external_count_pin_i(external_count_pin_i), .irq_req_o(irq_req_o),
        .irq_done_i(irq_done_i), .compare_output_a_o(compare_output_a_o),
        .compare_output_b_o(compare_output_b_o), .override_a_o(override_a_o),
        .override_b_o(override_b_o)
    );

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    // one classic cycle; held until ack is sampled high, bounded wait
    task automatic xfer(input logic [7:0] a, input logic we,
                        input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a,
                  dat: {24'h000000, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_o.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("[ERR] bus ack expected 1 seen %b", wb_o.ack);
        end
        r = wb_o.dat[7:0];
        wb_i.cyc <= 1'b0;
        wb_i.stb <= 1'b0;
        wb_i.we <= 1'b0;
        // idle edge: a write committed at the ack edge is now visible
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        xfer(a, 1'b0, 8'h00, r);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(OFF_COUNT, q);
        `CHK("count reset", RST_CNT, q)
        rd(OFF_CMP_A, q);
        `CHK("cmp a reset", RST_CMP, q)
        rd(OFF_FLAG, q);
        `CHK("flags reset", 8'h00, q)
        wr(8'h20, 8'h5a);
        rd(8'h20, q);
        `CHK("unmapped read", 8'h00, q)
        $display("test reset done");
    endtask

    // stopped counter holds a written value; a write beats running ticks
    task automatic t_count_access;
        wr(OFF_COUNT, 8'h5a);
        repeat (10) @(posedge clk_i);
        rd(OFF_COUNT, q);
        `CHK("stopped count", 8'h5a, q)
        wr(OFF_CTRL_B, {5'h00, CS_DIV1});
        wr(OFF_COUNT, 8'h50);
        rd(OFF_COUNT, q);
        wr(OFF_CTRL_B, 8'h00);
        `CHK("count write wins", 1'b1, q >= 8'h50 && q < 8'h58)
        $display("test count access done");
    endtask

    // wrap sets overflow and compare a; selective clear and executed clear
    task automatic t_overflow;
        wr(OFF_CMP_A, 8'h00);
        wr(OFF_MASK, 8'h03);
        wr(OFF_COUNT, 8'hf8);
        wr(OFF_CTRL_B, {5'h00, CS_DIV1});
        repeat (20) @(posedge clk_i);
        wr(OFF_CTRL_B, 8'h00);
        rd(OFF_FLAG, q);
        `CHK("ovf and cmp a flags", 3'h3, q[2:0] & 3'h3)
        `CHK("irq request", 2'h3, irq_req_o[1:0])
        wr(OFF_FLAG, 8'h01);
        rd(OFF_FLAG, q);
        `CHK("clear only ovf", 2'h2, q[1:0])
        @(posedge clk_i);
        irq_done_i <= 3'h2;
        @(posedge clk_i);
        irq_done_i <= 3'h0;
        rd(OFF_FLAG, q);
        `CHK("executed clears", 2'h0, q[1:0])
        `CHK("irq dropped", 2'h0, irq_req_o[1:0])
        $display("test overflow done");
    endtask

    // force strobe toggles output only; output mode acts at once
    task automatic t_force;
        wr(OFF_FLAG, 8'h07);
        wr(OFF_CTRL_A, 8'h40);
        `CHK("override a", 2'h2, {override_a_o, override_b_o})
        wr(OFF_COUNT, 8'hfe);
        oc_before = compare_output_a_o;
        wr(OFF_CTRL_C, 8'h80);
        repeat (2) @(posedge clk_i);
        `CHK("forced toggle", ~oc_before, compare_output_a_o)
        rd(OFF_FLAG, q);
        `CHK("force no flag", 8'h00, q)
        rd(OFF_COUNT, q);
        `CHK("force no clear", 8'hfe, q)
        wr(OFF_CTRL_A, 8'h03);
        `CHK("override off", 1'b0, override_a_o)
        `CHK("state kept", ~oc_before, compare_output_a_o)
        wr(OFF_CTRL_A, 8'h00);
        $display("test force done");
    endtask

    // count written equal to compare b: first tick match is suppressed
    task automatic t_block;
        wr(OFF_CMP_B, 8'h30);
        wr(OFF_COUNT, 8'h30);
        wr(OFF_FLAG, 8'h07);
        wr(OFF_CTRL_B, {5'h00, CS_DIV1});
        wr(OFF_CTRL_B, 8'h00);
        rd(OFF_FLAG, q);
        `CHK("blocked match", 1'b0, q[FL_CMP_B])
        $display("test block done");
    endtask

    // rising pin edges each give one tick
    task automatic t_ext_pin;
        wr(OFF_COUNT, 8'h00);
        wr(OFF_CTRL_B, {5'h00, CS_EXT_RISE});
        repeat (4) begin
            @(posedge clk_i);
            external_count_pin_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            external_count_pin_i <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
        rd(OFF_COUNT, q);
        `CHK("pin ticks", 8'h04, q)
        wr(OFF_CTRL_B, 8'h00);
        $display("test pin done");
    endtask

    // pwm mode buffers compare a; active value waits for top
    task automatic t_pwm_buffer;
        wr(OFF_CMP_A, 8'hf0);
        wr(OFF_CTRL_A, 8'h03);
        wr(OFF_CMP_A, 8'h80);
        rd(OFF_CMP_A, q);
        `CHK("buffer readback", 8'h80, q)
        wr(OFF_COUNT, 8'h70);
        wr(OFF_FLAG, 8'h07);
        wr(OFF_CTRL_B, {5'h00, CS_DIV1});
        repeat (20) @(posedge clk_i);
        wr(OFF_CTRL_B, 8'h00);
        rd(OFF_FLAG, q);
        `CHK("no early match", 1'b0, q[FL_CMP_A])
        $display("test pwm buffer done");
    endtask

    // clear-on-match: count stays within 0..cmp a, direct compare write
    task automatic t_ctc;
        wr(OFF_CTRL_A, {5'h00, WM_CTC});
        wr(OFF_CMP_A, 8'h05);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_FLAG, 8'h07);
        wr(OFF_CTRL_B, {5'h00, CS_DIV1});
        repeat (40) @(posedge clk_i);
        rd(OFF_COUNT, q);
        wr(OFF_CTRL_B, 8'h00);
        `CHK("ctc range", 1'b1, q <= 8'h05)
        rd(OFF_FLAG, q);
        `CHK("ctc match flag", 1'b1, q[FL_CMP_A])
        $display("test ctc done");
    endtask

    // clock enable low freezes the running counter
    task automatic t_freeze;
        wr(OFF_CTRL_A, 8'h00);
        wr(OFF_COUNT, 8'h40);
        wr(OFF_CTRL_B, {5'h00, CS_DIV1});
        ce_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        ce_i <= 1'b1;
        wr(OFF_CTRL_B, 8'h00);
        rd(OFF_COUNT, q);
        `CHK("frozen count", 1'b1, q >= 8'h41 && q < 8'h48)
        $display("test freeze done");
    endtask

    // ------------------------------------------------------------
    // verdict and sequence
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the tests need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_of_test;
    end

    // main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_count_access;
        t_overflow;
        t_force;
        t_block;
        t_ext_pin;
        t_pwm_buffer;
        t_ctc;
        t_freeze;
        end_of_test;
    end
endmodule // testbench
